// ### mrs_pkg.sv
// Shared constants, register map and decode functions for the mode registers.
package mrs_pkg;
  localparam logic [7:0] MA_INFO  = 8'h00;
  localparam logic [7:0] MA_BURST = 8'h01;
  localparam logic [7:0] MA_LAT   = 8'h02;
  localparam logic [7:0] MA_CAL   = 8'h0a;
  localparam logic [7:0] MA_RESET = 8'h3f;
  localparam logic [7:0] MA_LIMIT = 8'h40;
  localparam logic [7:0] OP_ZQ_INIT = 8'hff;
  localparam logic [7:0] MR1_RST = 8'h03;
  localparam logic [7:0] MR2_RST = 8'h18;
  localparam logic [7:0] MR1_RSVD = 8'h18;
  localparam logic [7:0] MR2_RSVD = 8'h20;
  localparam logic [2:0] BL8 = 3'h3;
  localparam int WRE_BIT = 4;
  localparam int WLSEL_BIT = 6;
  localparam int WLEV_BIT = 7;
  localparam int CLK_PERIOD_NS = 40;
  localparam int INIT_TIME_NS = 10000;
  localparam int ZQ_INIT_TIME_NS = 1000;
  localparam int WR_TIME_NS = 15;
  localparam int INIT_CYCLES =
    (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ZQ_CYCLES =
    (ZQ_INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYCLES_MIN =
    (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BEAT_LAST = 4'h7;
  localparam logic [11:0] CSR_CMD    = 12'h000;
  localparam logic [11:0] CSR_STATUS = 12'h004;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_ADDR_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_DATA_LSB = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Write recovery in cycles; zero marks a reserved code.
  function automatic logic [4:0] wr_decode(input logic ext,
                                           input logic [2:0] code);
    case ({ext, code})
      4'h1: wr_decode = 5'h03;
      4'h4: wr_decode = 5'h06;
      4'h6: wr_decode = 5'h08;
      4'h7: wr_decode = 5'h09;
      4'h8: wr_decode = 5'h0a;
      4'h9: wr_decode = 5'h0b;
      4'ha: wr_decode = 5'h0c;
      4'hc: wr_decode = 5'h0e;
      4'he: wr_decode = 5'h10;
      default: wr_decode = 5'h00;
    endcase
  endfunction

  // Returns {read latency, write latency}; zero marks a reserved code.
  function automatic logic [8:0] lat_decode(input logic setb,
                                            input logic [3:0] code);
    case (code)
      4'h1: lat_decode = {5'h03, 4'h1};
      4'h4: lat_decode = {5'h06, 4'h3};
      4'h6: lat_decode = {5'h08, 4'h4};
      4'h7: lat_decode = {5'h09, 4'h5};
      4'h8: lat_decode = {5'h0a, setb ? 4'h8 : 4'h6};
      4'h9: lat_decode = {5'h0b, setb ? 4'h9 : 4'h6};
      4'ha: lat_decode = {5'h0c, setb ? 4'h9 : 4'h6};
      4'hc: lat_decode = {5'h0e, setb ? 4'hb : 4'h8};
      4'he: lat_decode = {5'h10, setb ? 4'hd : 4'h8};
      default: lat_decode = 9'h000;
    endcase
  endfunction

  function automatic logic ma_reserved(input logic [7:0] a);
    ma_reserved = (a >= MA_LIMIT) || (a >= 8'h0c && a <= 8'h0f) ||
      (a >= 8'h12 && a <= 8'h1f) || (a >= 8'h21 && a <= 8'h27) ||
      (a >= 8'h2b && a <= 8'h2f) || (a >= 8'h31 && a <= 8'h3e);
  endfunction
endpackage

// ### mrs_if.sv
// Mode register command and read-burst link between controller and die.
`timescale 1ns/100ps
`default_nettype none
interface mrs_if;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       cmd_write;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_op;
  logic       rd_valid;
  logic       rd_strobe;
  logic       rd_last;
  logic [7:0] rd_data;
  modport dev (input cmd_valid, cmd_write, cmd_addr, cmd_op,
               output cmd_ready, rd_valid, rd_strobe, rd_last, rd_data);
  modport ctl (output cmd_valid, cmd_write, cmd_addr, cmd_op,
               input cmd_ready, rd_valid, rd_strobe, rd_last, rd_data);
endinterface
`default_nettype wire

// ### mrs_burst_seq.sv
// Eight-beat column order generator that wraps within the burst.
`timescale 1ns/100ps
`default_nettype none
module mrs_burst_seq (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [1:0] col_hi,
  output logic      [2:0] word,
  output logic            active
);
  logic [2:0] base_q;
  logic [3:0] beat_q;
  logic       run_q;
  logic [2:0] next_word;

  assign next_word = run_q ? base_q + beat_q[2:0] : {col_hi, 1'b0};

  always_ff @(posedge clk) begin
    if (rst) begin
      base_q <= 3'h0;
      beat_q <= 4'h0;
      run_q  <= 1'b0;
      word   <= 3'h0;
      active <= 1'b0;
    end else begin
      if (start && !run_q) begin
        base_q <= {col_hi, 1'b0};
        beat_q <= 4'h1;
        run_q  <= 1'b1;
      end else if (run_q) begin
        beat_q <= beat_q + 4'h1;
        run_q  <= beat_q[2:0] != 3'h0 || beat_q == 4'h1;
        if (beat_q == 4'h8) run_q <= 1'b0;
      end
      active <= (start && !run_q) || (run_q && beat_q != 4'h8);
      word   <= next_word;
    end
  end
endmodule
`default_nettype wire

// ### mrs_device.sv
// Die-side mode register bank with status, config decode and resets.
// What this block and the controller do
// - Controller writes zero into reserved bits.
// - Reserved bits of readable registers read zero.
// - Unreadable register reads still strobe, data reads zero.
// - Controller never writes reserved register addresses.
// - Writes to read-only registers are ignored.
// - Info bit 0 shows auto-initialization running.
// - Info bits 4:3 report calibration pin self-test.
// - Self-test field updates when calibration command completes.
// - Assembly error forces factory trim, ignores calibration.
// - Info bit 6 flags alternate write latency support.
// - Info bit 7 flags low latency support.
// - Burst length field accepts only code 011.
// - Unextended write recovery codes decode 3,6,8,9.
// - Extended write recovery codes decode 10,11,12,14,16.
// - Auto-precharge starts after programmed recovery cycles.
// - Lowest column bit zero; burst wraps ascending.
// - Feature 2 bit 6 selects latency set.
// - Feature 2 bit 7 enables write leveling.
// - Feature 2 bits 3:0 select latency pair.
`timescale 1ns/100ps
`default_nettype none
module mrs_device #(
  parameter logic ALT_WL_SUPPORT = 1'b1,
  parameter logic LOW_RL_SUPPORT = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst,
  mrs_if.dev              link,
  input  wire logic [1:0] zq_pin_state,
  input  wire logic       ap_write_done,
  input  wire logic       burst_start,
  input  wire logic [1:0] burst_col,
  output logic            auto_init_busy,
  output logic            write_leveling_en,
  output logic            wl_set_b,
  output logic      [4:0] read_latency,
  output logic      [3:0] write_latency,
  output logic      [4:0] write_recovery_cycles,
  output logic            factory_trim,
  output logic            precharge_start,
  output logic      [2:0] burst_word,
  output logic            burst_word_valid
);
  logic [7:0]  mr1_q;
  logic [7:0]  mr2_q;
  logic [1:0]  zq_q;
  logic        trim_q;
  logic        zq_busy_q;
  logic [7:0]  zq_cnt_q;
  logic [11:0] init_cnt_q;
  logic        dai_q;
  logic        ready_q;
  logic        rd_valid_q;
  logic        rd_strobe_q;
  logic        rd_last_q;
  logic [3:0]  rd_cnt_q;
  logic [7:0]  rd_data_q;
  logic [4:0]  pre_cnt_q;
  logic        pre_q;

  logic        fire;
  logic        wr_fire;
  logic        rd_start;
  logic        soft_rst;
  logic        any_rst;
  logic        mr1_hit;
  logic        mr2_hit;
  logic        zq_hit;
  logic        zq_done;
  logic        zq_fault;
  logic [7:0]  info_word;
  logic [7:0]  rd_word;
  logic [8:0]  lat_pair;
  logic        rd_busy_d;

  assign fire     = link.cmd_valid && ready_q;
  assign wr_fire  = fire && link.cmd_write;
  assign rd_start = fire && !link.cmd_write;
  // A reset write acts whatever its operand holds.
  assign soft_rst = wr_fire && link.cmd_addr == mrs_pkg::MA_RESET;
  assign any_rst  = rst || soft_rst;
  assign mr1_hit  = wr_fire && link.cmd_addr == mrs_pkg::MA_BURST &&
                    link.cmd_op[2:0] == mrs_pkg::BL8;
  assign mr2_hit  = wr_fire && link.cmd_addr == mrs_pkg::MA_LAT;
  // Once a fault is latched later calibration requests are dropped.
  assign zq_hit   = wr_fire && link.cmd_addr == mrs_pkg::MA_CAL &&
                    link.cmd_op == mrs_pkg::OP_ZQ_INIT &&
                    !trim_q && !zq_busy_q;
  assign zq_done  = zq_busy_q &&
                    zq_cnt_q == 8'(mrs_pkg::ZQ_CYCLES - 1);
  assign zq_fault = zq_pin_state == 2'h1 ||
                    zq_pin_state == 2'h2;
  // Reserved positions of the info word are tied low.
  assign info_word = {LOW_RL_SUPPORT,
                      ALT_WL_SUPPORT,
                      1'b0, zq_q, 2'b00,
                      dai_q};
  // Other addresses return zero data, still as a full burst.
  assign rd_word = link.cmd_addr == mrs_pkg::MA_INFO ?
                   info_word : 8'h00;
  assign lat_pair = mrs_pkg::lat_decode(mr2_q[mrs_pkg::WLSEL_BIT],
                                        mr2_q[3:0]);
  assign rd_busy_d = rd_start || (rd_valid_q && !rd_last_q);

  assign link.cmd_ready = ready_q;
  assign link.rd_valid  = rd_valid_q;
  assign link.rd_strobe = rd_strobe_q;
  assign link.rd_last   = rd_last_q;
  assign link.rd_data   = rd_data_q;

  // Mode register contents; info-register writes fall through untouched.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      mr1_q <= mrs_pkg::MR1_RST;
      mr2_q <= mrs_pkg::MR2_RST;
    end else begin
      if (mr1_hit) mr1_q <= link.cmd_op & ~mrs_pkg::MR1_RSVD;
      if (mr2_hit) mr2_q <= link.cmd_op & ~mrs_pkg::MR2_RSVD;
    end
  end

  // Auto-initialization runs after every reset, hard or soft.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      dai_q      <= 1'b1;
      init_cnt_q <= 12'h000;
    end else if (dai_q) begin
      init_cnt_q <= init_cnt_q + 12'h001;
      if (init_cnt_q == 12'(mrs_pkg::INIT_CYCLES - 1))
        dai_q <= 1'b0;
    end
  end

  // Calibration self-test result is sampled when the command finishes.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      zq_q      <= 2'h0;
      trim_q    <= 1'b0;
      zq_busy_q <= 1'b0;
      zq_cnt_q  <= 8'h00;
    end else begin
      if (zq_hit) begin
        zq_busy_q <= 1'b1;
        zq_cnt_q  <= 8'h00;
      end else if (zq_busy_q) begin
        zq_cnt_q <= zq_cnt_q + 8'h01;
      end
      if (zq_done) begin
        zq_busy_q <= 1'b0;
        zq_q      <= zq_pin_state;
        trim_q    <= zq_fault;
      end
    end
  end

  // Read burst: eight beats with a toggling strobe, data held all burst.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      ready_q     <= 1'b0;
      rd_valid_q  <= 1'b0;
      rd_strobe_q <= 1'b0;
      rd_last_q   <= 1'b0;
      rd_cnt_q    <= 4'h0;
      rd_data_q   <= 8'h00;
    end else begin
      ready_q <= !rd_busy_d;
      if (rd_start) begin
        rd_valid_q  <= 1'b1;
        rd_cnt_q    <= 4'h0;
        rd_data_q   <= rd_word;
        rd_strobe_q <= 1'b1;
        rd_last_q   <= 1'b0;
      end else if (rd_valid_q && !rd_last_q) begin
        rd_cnt_q    <= rd_cnt_q + 4'h1;
        rd_strobe_q <= !rd_strobe_q;
        rd_last_q   <= rd_cnt_q == mrs_pkg::BEAT_LAST - 4'h1;
      end else begin
        rd_valid_q  <= 1'b0;
        rd_strobe_q <= 1'b0;
        rd_last_q   <= 1'b0;
      end
    end
  end

  // A reserved recovery code decodes to zero and never fires precharge.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      pre_cnt_q <= 5'h00;
      pre_q     <= 1'b0;
    end else begin
      pre_q <= pre_cnt_q == 5'h01;
      if (ap_write_done) begin
        pre_cnt_q <= write_recovery_cycles;
      end else if (pre_cnt_q != 5'h00) begin
        pre_cnt_q <= pre_cnt_q - 5'h01;
      end
    end
  end

  // Decoded settings seen by the rest of the die.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      auto_init_busy        <= 1'b1;
      write_leveling_en     <= 1'b0;
      wl_set_b              <= 1'b0;
      read_latency          <= 5'h00;
      write_latency         <= 4'h0;
      write_recovery_cycles <= 5'h00;
      factory_trim          <= 1'b0;
      precharge_start       <= 1'b0;
    end else begin
      auto_init_busy        <= dai_q;
      write_leveling_en     <= mr2_q[mrs_pkg::WLEV_BIT];
      wl_set_b              <= mr2_q[mrs_pkg::WLSEL_BIT];
      read_latency          <= lat_pair[8:4];
      write_latency         <= lat_pair[3:0];
      write_recovery_cycles <= mrs_pkg::wr_decode(
        mr2_q[mrs_pkg::WRE_BIT],
        mr1_q[7:5]);
      factory_trim          <= trim_q;
      precharge_start       <= pre_q;
    end
  end

  mrs_burst_seq u_seq (
    .clk    (clk),
    .rst    (any_rst),
    .start  (burst_start),
    .col_hi (burst_col),
    .word   (burst_word),
    .active (burst_word_valid)
  );
endmodule
`default_nettype wire

// ### mrs_host.sv
// Controller end: AXI4-Lite command and status registers driving the link.
`timescale 1ns/100ps
`default_nettype none
module mrs_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  mrs_if.ctl               link
);
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic        cv_q;
  logic        cw_q;
  logic [7:0]  ca_q;
  logic [7:0]  co_q;
  logic        busy_q;
  logic        err_q;
  logic        got_q;
  logic [7:0]  data_q;
  logic        ext_q;
  logic        ws_q;
  logic        exec;
  logic        is_cmd;
  logic        c_wr;
  logic [7:0]  c_ma;
  logic [7:0]  c_op;
  logic [4:0]  c_wr_cyc;
  logic        c_bad;
  logic [31:0] status_word;

  assign exec   = aw_have_q && w_have_q && !bvalid;
  assign is_cmd = aw_q == mrs_pkg::CSR_CMD;
  assign c_wr   = w_q[mrs_pkg::CMD_WRITE_BIT];
  assign c_ma   = w_q[mrs_pkg::CMD_ADDR_LSB +: 8];
  // Reserved operand positions are forced low before sending.
  assign c_op   = c_ma == mrs_pkg::MA_BURST ? w_q[7:0] & ~mrs_pkg::MR1_RSVD :
                  c_ma == mrs_pkg::MA_LAT ? w_q[7:0] & ~mrs_pkg::MR2_RSVD :
                  w_q[7:0];
  assign c_wr_cyc = mrs_pkg::wr_decode(ext_q, c_op[7:5]);
  assign c_bad  = c_wr && (mrs_pkg::ma_reserved(c_ma) ||
                  (c_ma == mrs_pkg::MA_BURST &&
                   (c_op[2:0] != mrs_pkg::BL8 ||
                    c_wr_cyc < 5'(mrs_pkg::WR_CYCLES_MIN))));
  assign status_word = {16'h0000, data_q, 6'h00, err_q, busy_q};

  assign link.cmd_valid = cv_q;
  assign link.cmd_write = cw_q;
  assign link.cmd_addr  = ca_q;
  assign link.cmd_op    = co_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h00000000;
      bvalid <= 1'b0;
      bresp <= mrs_pkg::AXI_OKAY;
      cv_q <= 1'b0;
      cw_q <= 1'b0;
      ca_q <= 8'h00;
      co_q <= 8'h00;
      busy_q <= 1'b0;
      err_q <= 1'b0;
      got_q <= 1'b0;
      data_q <= 8'h00;
      ext_q <= mrs_pkg::MR2_RST[mrs_pkg::WRE_BIT];
      ws_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_q <= awaddr;
        aw_have_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q <= wdata;
        // The strobes are only valid in the cycle that the word is taken.
        ws_q <= wstrb_ok(wstrb);
        w_have_q <= 1'b1;
        wready <= 1'b0;
      end
      if (exec) begin
        bvalid <= 1'b1;
        bresp <= mrs_pkg::AXI_OKAY;
        if (is_cmd && !busy_q && ws_q) begin
          err_q <= c_bad;
          if (!c_bad) begin
            cv_q <= 1'b1;
            cw_q <= c_wr;
            ca_q <= c_ma;
            co_q <= c_op;
            busy_q <= 1'b1;
            got_q <= 1'b0;
            if (c_wr && c_ma == mrs_pkg::MA_LAT)
              ext_q <= c_op[mrs_pkg::WRE_BIT];
            if (c_wr && c_ma == mrs_pkg::MA_RESET)
              ext_q <= mrs_pkg::MR2_RST[mrs_pkg::WRE_BIT];
          end
        end else if (aw_q != mrs_pkg::CSR_STATUS) begin
          bresp <= mrs_pkg::AXI_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (cv_q && link.cmd_ready) begin
        cv_q <= 1'b0;
        if (cw_q) busy_q <= 1'b0;
      end
      if (busy_q && !cw_q && link.rd_valid && !got_q) begin
        data_q <= link.rd_data;
        got_q <= 1'b1;
      end
      if (busy_q && !cw_q && link.rd_last) busy_q <= 1'b0;
    end
  end

  // Register words are written whole; partial strobes are refused.
  function automatic logic wstrb_ok(input logic [3:0] s);
    wstrb_ok = s == 4'hf;
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= mrs_pkg::AXI_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      if (araddr == mrs_pkg::CSR_STATUS) begin
        rdata <= status_word;
        rresp <= mrs_pkg::AXI_OKAY;
      end else if (araddr == mrs_pkg::CSR_CMD) begin
        rdata <= {15'h0000, cw_q, ca_q, co_q};
        rresp <= mrs_pkg::AXI_OKAY;
      end else begin
        rdata <= 32'h00000000;
        rresp <= mrs_pkg::AXI_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### mrs_asserts.sv
// Link assertions between the controller end and the die end.
`timescale 1ns/100ps
`default_nettype none
module mrs_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_op,
  input wire logic       rd_valid,
  input wire logic       rd_strobe,
  input wire logic       rd_last,
  input wire logic [7:0] rd_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Writes are judged when offered, since a bad one must never appear.
  wire logic rd_go = cmd_valid && cmd_ready && !cmd_write;
  wire logic wr_go = cmd_valid && cmd_write;
  chk_burst_len: assert property (
    rd_go |=> (rd_valid && !rd_last)[*7] ##1 (rd_valid && rd_last))
    else $error("read burst length wrong");
  chk_strobe_flip: assert property (
    rd_valid && !rd_last |=> rd_strobe != $past(rd_strobe))
    else $error("strobe did not toggle");
  chk_burst_end: assert property (
    rd_last |=> !rd_valid && cmd_ready)
    else $error("burst did not end cleanly");
  chk_no_take_busy: assert property (rd_valid |-> !cmd_ready)
    else $error("ready during burst");
  chk_info_rsvd: assert property (
    rd_go && cmd_addr == mrs_pkg::MA_INFO |=> (rd_data & 8'h26) == 8'h00)
    else $error("reserved info bits set");
  chk_data_hold: assert property (
    rd_valid && !rd_last |=> $stable(rd_data))
    else $error("read data changed in burst");
  chk_unread_zero: assert property (
    rd_go && cmd_addr != mrs_pkg::MA_INFO |=> rd_data == 8'h00)
    else $error("unreadable register gave data");
  chk_mr1_legal: assert property (
    wr_go && cmd_addr == mrs_pkg::MA_BURST |->
      (cmd_op & mrs_pkg::MR1_RSVD) == 8'h00 &&
      cmd_op[2:0] == mrs_pkg::BL8)
    else $error("bad feature 1 operand");
  chk_mr2_rsvd: assert property (
    wr_go && cmd_addr == mrs_pkg::MA_LAT |->
      (cmd_op & mrs_pkg::MR2_RSVD) == 8'h00)
    else $error("feature 2 reserved bit set");
  chk_addr_legal: assert property (
    wr_go |-> !mrs_pkg::ma_reserved(cmd_addr))
    else $error("write to reserved address");
  cov_read: cover property (rd_go);
  cov_reset: cover property (wr_go && cmd_addr == mrs_pkg::MA_RESET);
  cov_done: cover property (rd_last);
endmodule
`default_nettype wire

// ### tb_top.sv
// Bench driving the controller registers and watching the die outputs.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        apd, bst, busy, lev, setb, trim, pre, bwv;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [1:0]  bresp, rresp, zq, bcol;
  logic [4:0]  rl, wr;
  logic [3:0]  wl;
  logic [2:0]  bw;
  int          failures, compares, n;
  wire logic [15:0] cfg = {lev, setb, rl, wl, wr};
  // Each row: feature 1 op, feature 2 op, {lev, set b, rl, wl, wr}.
  logic [31:0] rows [10] = '{
    {8'h23, 8'h04, 2'h0, 5'h06, 4'h3, 5'h03},
    {8'h83, 8'h00, 2'h0, 5'h00, 4'h0, 5'h06},
    {8'hc3, 8'h06, 2'h0, 5'h08, 4'h4, 5'h08},
    {8'he3, 8'h07, 2'h0, 5'h09, 4'h5, 5'h09},
    {8'h23, 8'h59, 2'h1, 5'h0b, 4'h9, 5'h0b},
    {8'h03, 8'h58, 2'h1, 5'h0a, 4'h8, 5'h0a},
    {8'h43, 8'h5a, 2'h1, 5'h0c, 4'h9, 5'h0c},
    {8'h83, 8'hdc, 2'h3, 5'h0e, 4'hb, 5'h0e},
    {8'hc3, 8'h9e, 2'h2, 5'h10, 4'h8, 5'h10},
    {8'h43, 8'h1a, 2'h0, 5'h0c, 4'h6, 5'h0c}};
  mrs_if link ();
  mrs_device #(.ALT_WL_SUPPORT(1'b1), .LOW_RL_SUPPORT(1'b0)) u_mrs_device (
    .clk(clk), .rst(rst), .link(link.dev), .zq_pin_state(zq),
    .ap_write_done(apd), .burst_start(bst), .burst_col(bcol),
    .auto_init_busy(busy), .write_leveling_en(lev), .wl_set_b(setb),
    .read_latency(rl), .write_latency(wl), .write_recovery_cycles(wr),
    .factory_trim(trim), .precharge_start(pre), .burst_word(bw),
    .burst_word_valid(bwv));
  mrs_host u_mrs_host (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link.ctl));
  mrs_asserts u_mrs_asserts (
    .clk(clk), .rst(rst), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cmd_write(link.cmd_write),
    .cmd_addr(link.cmd_addr), .cmd_op(link.cmd_op),
    .rd_valid(link.rd_valid), .rd_strobe(link.rd_strobe),
    .rd_last(link.rd_last), .rd_data(link.rd_data));

  task automatic check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check(bresp, er);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        input logic [1:0] er);
    d = '0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    check(rresp, er);
    rready <= 1'b0;
  endtask

  // Busy must be polled: the host accepts one command at a time.
  task automatic mr_cmd(input logic w, input logic [7:0] a, op,
                        output logic [31:0] s);
    axi_wr(mrs_pkg::CSR_CMD, {15'h0000, w, a, op}, mrs_pkg::AXI_OKAY);
    do begin
      axi_rd(mrs_pkg::CSR_STATUS, s, mrs_pkg::AXI_OKAY);
    end while (s[0]);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test;
  end

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, apd, bst} = '0;
    {awaddr, araddr, wdata, zq, bcol} = '0;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(busy, 1'b1);
    mr_cmd(1'b0, mrs_pkg::MA_INFO, 8'h00, st);
    check(st[15:8], 8'h41);
    repeat (260) @(posedge clk);
    mr_cmd(1'b0, mrs_pkg::MA_INFO, 8'h00, st);
    check({busy, st[15:8]}, 9'h040);
    check(cfg, {2'h0, 5'h0a, 4'h6, 5'h0a});
    foreach (rows[r]) begin
      mr_cmd(1'b1, mrs_pkg::MA_BURST, rows[r][31:24], st);
      mr_cmd(1'b1, mrs_pkg::MA_LAT, rows[r][23:16], st);
      check(cfg, rows[r][15:0]);
      @(posedge clk);
      apd <= 1'b1;
      @(posedge clk);
      apd <= 1'b0;
      n = 0;
      while (!pre && n < 40) begin
        @(posedge clk);
        #1;
        n++;
      end
      check(n, rows[r][4:0] + 32'd1);
    end
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      bst <= 1'b1;
      bcol <= 2'(c);
      @(posedge clk);
      bst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        #1;
        check({bwv, bw}, {1'b1, 3'(2 * c + i)});
        @(posedge clk);
      end
      #1;
      check(bwv, 1'b0);
    end
    // A fault must stick, so the third pass with a good pin changes nothing.
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      zq <= (k == 1) ? 2'h1 : 2'h3;
      mr_cmd(1'b1, mrs_pkg::MA_CAL, mrs_pkg::OP_ZQ_INIT, st);
      repeat (mrs_pkg::ZQ_CYCLES + 3) @(posedge clk);
      mr_cmd(1'b0, mrs_pkg::MA_INFO, 8'h00, st);
      check({trim, st[15:8]}, (k > 0) ? 9'h148 : 9'h058);
    end
    mr_cmd(1'b1, mrs_pkg::MA_INFO, 8'hff, st);
    mr_cmd(1'b0, mrs_pkg::MA_INFO, 8'h00, st);
    check({trim, st[15:8]}, 9'h148);
    mr_cmd(1'b0, mrs_pkg::MA_BURST, 8'h00, st);
    check(st[15:8], 8'h00);
    mr_cmd(1'b1, 8'h40, 8'h00, st);
    check(st[1], 1'b1);
    mr_cmd(1'b1, mrs_pkg::MA_BURST, 8'h42, st);
    check({st[1], wr}, 6'h2c);
    axi_wr(12'h008, 32'h0000_0000, mrs_pkg::AXI_SLVERR);
    axi_rd(12'h008, st, mrs_pkg::AXI_SLVERR);
    mr_cmd(1'b1, mrs_pkg::MA_RESET, 8'h5a, st);
    check({busy, trim, cfg}, {2'h2, 2'h0, 5'h0a, 4'h6, 5'h0a});
    // The reserved bit 5 must be stripped before the command goes out.
    mr_cmd(1'b1, mrs_pkg::MA_LAT, 8'hfc, st);
    axi_rd(mrs_pkg::CSR_CMD, st, mrs_pkg::AXI_OKAY);
    check(st, {15'h0000, 1'b1, mrs_pkg::MA_LAT, 8'hdc});
    check({lev, setb}, 2'h3);
    // A hard reset in mid-run must undo the settings just written.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({busy, cfg}, {3'h4, 5'h0a, 4'h6, 5'h0a});
    stop_test;
  end
endmodule
`default_nettype wire
